// ===== hdl/host_port_pkg.sv
// Shared constants and types for the multiplexed host bus port
package host_port_pkg;

  localparam int AD_W     = 16;
  localparam int ADDR_W   = 10;
  localparam int DW       = 32;
  localparam int BYTE_W   = 8;
  localparam int HALF_W   = 16;
  localparam int CNT_W    = 3;

  // Pieces per DWORD in each width
  localparam logic [CNT_W-1:0] PIECES_8  = 3'h4;
  localparam logic [CNT_W-1:0] PIECES_16 = 3'h2;
  localparam logic [CNT_W-1:0] CNT_ONE   = 3'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 3'h0;

  // Cycles after reset before both synchroniser stages and the edge registers hold real pin levels
  localparam int                WARM_W    = 2;
  localparam logic [WARM_W-1:0] WARM_ZERO = 2'h0;
  localparam logic [WARM_W-1:0] WARM_ONE  = 2'h1;
  localparam logic [WARM_W-1:0] WARM_FULL = 2'h3;

  // Pin positions of endianness and FIFO select, one and two above the top address bit
  localparam int SP8_ENDIAN   = 10;
  localparam int SP8_FIFO     = 11;
  localparam int SP16_ENDIAN  = 9;
  localparam int SP16_FIFO    = 10;
  localparam int DP8_ENDIAN   = 2;
  localparam int DP8_FIFO     = 3;
  localparam int DP16_ENDIAN  = 1;
  localparam int DP16_FIFO    = 2;

  localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000;
  localparam logic [AD_W-1:0]   OE_OFF   = 16'hFFFF;
  localparam logic [AD_W-1:0]   OE_ALL   = 16'h0000;
  localparam logic [AD_W-1:0]   OE_LOW8  = 16'hFF00;
  localparam logic [AD_W-1:0]   AD_ZERO  = 16'h0000;
  localparam logic [DW-1:0]     DW_ZERO  = 32'h0000_0000;

  typedef struct packed {
    logic width16;     // 1: 16-bit host bus, 0: 8-bit
    logic enb_mode;    // 1: access_enable plus direction, 0: separate strobes
    logic dual_phase;  // 1: two address phases on the low byte
    logic cs_qual;     // 1: address strobes need chip select
    logic cs_pol;      // Per pin: 1 active high, 0 active low
    logic rd_pol;
    logic wr_pol;
    logic lo_pol;
    logic hi_pol;
  } cfg_t;

  typedef struct packed {
    logic cs;
    logic rd_dir;       // Read strobe, or direction (active = read)
    logic wr_enb;       // Write strobe, or access_enable
    logic address_strobe_low_phase;
    logic address_strobe_high_phase;
  } strobe_t;

  typedef struct packed {
    logic              reg_wr;     // One-cycle DWORD write to registers
    logic              fifo_push;  // One-cycle DWORD push to write data FIFO
    logic [ADDR_W-1:0] addr;       // DWORD-aligned byte address
    logic [DW-1:0]     data;
  } wr_bus_t;

  typedef enum logic {RD_IDLE, RD_DRIVE} rd_state_t;

endpackage : host_port_pkg

// ===== hdl/muxed_host_bus_address_latch.sv
// Multiplexed address/data host bus port with address latch and DWORD assembly
`timescale 1ns/100ps
module muxed_host_bus_address_latch
  import host_port_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire cfg_t              cfg,
  input  wire strobe_t           pins,
  input  wire logic [AD_W-1:0]   ad_in,
  output logic      [AD_W-1:0]   ad_out,
  output logic      [AD_W-1:0]   ad_oe_n,
  input  wire logic [DW-1:0]     rd_data,
  output logic      [ADDR_W-1:0] lat_addr,
  output logic                   big_endian,
  output logic                   fifo_sel,
  output wr_bus_t                wr_bus,
  output logic                   rd_done,
  output logic                   rd_fifo_pop
);

  typedef struct packed {
    logic              lo_prev;
    logic              hi_prev;
    logic              cs_prev;
    logic              wr_prev;
    logic              rd_prev;
    logic [AD_W-1:0]   ad_prev;
    logic [ADDR_W-1:0] addr;
    logic              big_end;
    logic              fifo;
    logic [CNT_W-1:0]  wr_cnt;
    logic [CNT_W-1:0]  rd_cnt;
    logic [DW-1:0]     asm_buf;
    logic [DW-1:0]     hold;
    rd_state_t         rd_st;
    logic [AD_W-1:0]   ad_out;
    logic [AD_W-1:0]   oe_n;
    wr_bus_t           wr;
    logic              rd_done;
    logic              rd_pop;
    logic [WARM_W-1:0] warm;
  } state_t;

  localparam state_t ST_RST = '{
    lo_prev: 1'b0, hi_prev: 1'b0, cs_prev: 1'b0, wr_prev: 1'b0, rd_prev: 1'b0,
    ad_prev: AD_ZERO, addr: ADDR_RST, big_end: 1'b0, fifo: 1'b0,
    wr_cnt: CNT_ZERO, rd_cnt: CNT_ZERO, asm_buf: DW_ZERO, hold: DW_ZERO,
    rd_st: RD_IDLE, ad_out: AD_ZERO, oe_n: OE_OFF,
    wr: '{reg_wr: 1'b0, fifo_push: 1'b0, addr: ADDR_RST, data: DW_ZERO},
    rd_done: 1'b0, rd_pop: 1'b0, warm: WARM_ZERO};

  state_t st_q;
  state_t st_d;

  strobe_t         pins_s;
  logic [AD_W-1:0] ad_s;
  strobe_t         act;
  logic            wr_on;
  logic            rd_on;
  logic            lo_trail;
  logic            hi_trail;
  logic            qual_ok;
  logic            live;
  logic            wr_trail;
  logic            rd_lead;
  logic            rd_trail;
  logic [CNT_W-1:0] pieces;
  logic            w_idx;
  logic [1:0]      b_idx;
  logic [DW-1:0]   src;

  strobe_sync #(.W($bits(strobe_t))) u_sync_pins (
    .clk  (clk),
    .nrst (nrst),
    .d    (pins),
    .q    (pins_s)
  );

  // Bus pins travel with the strobes so they line up in time
  strobe_sync #(.W(AD_W)) u_sync_ad (
    .clk  (clk),
    .nrst (nrst),
    .d    (ad_in),
    .q    (ad_s)
  );

  always_comb
  begin
    act.cs                        = pins_s.cs ~^ cfg.cs_pol;
    act.rd_dir                    = pins_s.rd_dir ~^ cfg.rd_pol;
    act.wr_enb                    = pins_s.wr_enb ~^ cfg.wr_pol;
    act.address_strobe_low_phase  = pins_s.address_strobe_low_phase ~^ cfg.lo_pol;
    act.address_strobe_high_phase = pins_s.address_strobe_high_phase ~^ cfg.hi_pol;
    if (cfg.enb_mode)
    begin
      wr_on = act.wr_enb & ~act.rd_dir;
      rd_on = act.wr_enb & act.rd_dir;
    end
    else
    begin
      wr_on = act.cs & act.wr_enb;
      rd_on = act.cs & act.rd_dir;
    end
    // trailing and leading edges
    // Cleared synchronisers can read as active for some polarities, so edges wait
    live     = (st_q.warm == WARM_FULL);
    lo_trail = live & st_q.lo_prev & ~act.address_strobe_low_phase;
    hi_trail = live & st_q.hi_prev & ~act.address_strobe_high_phase;
    qual_ok  = ~cfg.cs_qual | st_q.cs_prev;
    wr_trail = live & st_q.wr_prev & ~wr_on;
    rd_lead  = live & ~st_q.rd_prev & rd_on;
    rd_trail = live & st_q.rd_prev & ~rd_on;
    pieces   = cfg.width16 ? PIECES_16 : PIECES_8;
    // big endian flips the lane index
    w_idx    = st_q.addr[1] ^ st_q.big_end;
    b_idx    = st_q.addr[1:0] ^ {2{st_q.big_end}};
    // Live value is held from the first piece on
    src      = (st_q.rd_cnt == CNT_ZERO) ? rd_data : st_q.hold;
  end

  always_comb
  begin
    st_d            = st_q;
    st_d.lo_prev    = act.address_strobe_low_phase;
    st_d.hi_prev    = act.address_strobe_high_phase;
    st_d.cs_prev    = act.cs;
    st_d.wr_prev    = wr_on;
    st_d.rd_prev    = rd_on;
    st_d.ad_prev    = ad_s;
    st_d.wr.reg_wr    = 1'b0;
    st_d.wr.fifo_push = 1'b0;
    st_d.rd_done    = 1'b0;
    st_d.rd_pop     = 1'b0;
    if (st_q.warm != WARM_FULL)
      st_d.warm = st_q.warm + WARM_ONE;

    if (!cfg.dual_phase && lo_trail && qual_ok)
    begin
      if (cfg.width16)
      begin
        st_d.addr    = {st_q.ad_prev[8:0], 1'b0};
        st_d.big_end = st_q.ad_prev[SP16_ENDIAN];
        st_d.fifo    = st_q.ad_prev[SP16_FIFO];
      end
      else
      begin
        st_d.addr    = st_q.ad_prev[ADDR_W-1:0];
        st_d.big_end = st_q.ad_prev[SP8_ENDIAN];
        st_d.fifo    = st_q.ad_prev[SP8_FIFO];
      end
    end

    // dual phase, low byte pins only
    if (cfg.dual_phase && lo_trail && qual_ok)
    begin
      if (cfg.width16)
        st_d.addr[8:0] = {st_q.ad_prev[7:0], 1'b0};
      else
        st_d.addr[7:0] = st_q.ad_prev[7:0];
    end
    if (cfg.dual_phase && hi_trail && qual_ok)
    begin
      if (cfg.width16)
      begin
        st_d.addr[9]  = st_q.ad_prev[0];
        st_d.big_end  = st_q.ad_prev[DP16_ENDIAN];
        st_d.fifo     = st_q.ad_prev[DP16_FIFO];
      end
      else
      begin
        st_d.addr[9:8] = st_q.ad_prev[1:0];
        st_d.big_end   = st_q.ad_prev[DP8_ENDIAN];
        st_d.fifo      = st_q.ad_prev[DP8_FIFO];
      end
    end

    if (wr_trail)
    begin
      if (cfg.width16)
        st_d.asm_buf[{w_idx, 4'h0} +: HALF_W] = st_q.ad_prev;
      else
        st_d.asm_buf[{b_idx, 3'h0} +: BYTE_W] = st_q.ad_prev[BYTE_W-1:0];
      st_d.wr_cnt = st_q.wr_cnt + CNT_ONE;
      // full DWORD goes to registers or FIFO
      if (st_d.wr_cnt == pieces)
      begin
        st_d.wr_cnt       = CNT_ZERO;
        st_d.wr.data      = st_d.asm_buf;
        st_d.wr.addr      = {st_q.addr[ADDR_W-1:2], 2'b00};
        st_d.wr.reg_wr    = ~st_q.fifo;
        st_d.wr.fifo_push = st_q.fifo;
      end
    end

    case (st_q.rd_st)
      RD_IDLE:
      begin
        // drive selected piece at cycle start
        if (rd_lead)
        begin
          st_d.hold  = src;
          st_d.rd_st = RD_DRIVE;
          if (cfg.width16)
          begin
            st_d.ad_out = src[{w_idx, 4'h0} +: HALF_W];
            st_d.oe_n   = OE_ALL;
          end
          else
          begin
            st_d.ad_out = {8'h00, src[{b_idx, 3'h0} +: BYTE_W]};
            st_d.oe_n   = OE_LOW8;
          end
        end
      end
      RD_DRIVE:
      begin
        if (rd_trail)
        begin
          st_d.rd_st  = RD_IDLE;
          st_d.oe_n   = OE_OFF;
          st_d.rd_cnt = st_q.rd_cnt + CNT_ONE;
          // last piece ends the DWORD read
          if (st_d.rd_cnt == pieces)
          begin
            st_d.rd_cnt  = CNT_ZERO;
            st_d.rd_done = ~st_q.fifo;
            st_d.rd_pop  = st_q.fifo;
          end
        end
      end
      default:
      begin
        st_d.rd_st = RD_IDLE;
        st_d.oe_n  = OE_OFF;
      end
    endcase
  end

  // address held until reset or new latch
  always_ff @(posedge clk)
  begin
    if (!nrst)
      st_q <= ST_RST;
    else
      st_q <= st_d;
  end

  assign ad_out      = st_q.ad_out;
  assign ad_oe_n     = st_q.oe_n;
  assign lat_addr    = st_q.addr;
  assign big_endian  = st_q.big_end;
  assign fifo_sel    = st_q.fifo;
  assign wr_bus      = st_q.wr;
  assign rd_done     = st_q.rd_done;
  assign rd_fifo_pop = st_q.rd_pop;

  property p_upper_quiet;
    @(posedge clk) disable iff (!nrst)
    !cfg.width16 |-> (ad_oe_n[15:8] == 8'hFF);
  endproperty
  a_upper_quiet: assert property (p_upper_quiet)
    else $error("upper pins driven in 8-bit mode");

  property p_addr_hold;
    @(posedge clk) disable iff (!nrst)
    !lo_trail && !hi_trail |=> $stable(lat_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address changed without a strobe");

  property p_qualify;
    @(posedge clk) disable iff (!nrst)
    cfg.cs_qual && !st_q.cs_prev |=> $stable(lat_addr) && $stable(fifo_sel);
  endproperty
  a_qualify: assert property (p_qualify)
    else $error("address latched without chip select");

  property p_sp8_map;
    @(posedge clk) disable iff (!nrst)
    !cfg.dual_phase && !cfg.width16 && lo_trail && qual_ok
      |=> lat_addr == $past(st_q.ad_prev[9:0]) && big_endian == $past(st_q.ad_prev[10]);
  endproperty
  a_sp8_map: assert property (p_sp8_map)
    else $error("single-phase 8-bit mapping wrong");

  property p_word_addr;
    @(posedge clk) disable iff (!nrst)
    cfg.width16 && !cfg.dual_phase && lo_trail && qual_ok |=> lat_addr[0] == 1'b0;
  endproperty
  a_word_addr: assert property (p_word_addr)
    else $error("16-bit address not word aligned");

  property p_route;
    @(posedge clk) disable iff (!nrst)
    wr_bus.fifo_push || rd_fifo_pop |-> fifo_sel && !wr_bus.reg_wr && !rd_done;
  endproperty
  a_route: assert property (p_route)
    else $error("FIFO access not routed to FIFO");

  property p_drive_start;
    @(posedge clk) disable iff (!nrst)
    rd_lead && st_q.rd_st == RD_IDLE |=> ad_oe_n[0] == 1'b0 [*1] ##1 (rd_on ? !ad_oe_n[0] : 1'b1);
  endproperty
  a_drive_start: assert property (p_drive_start)
    else $error("read data not driven at cycle start");

  property p_release;
    @(posedge clk) disable iff (!nrst)
    rd_trail |=> ad_oe_n == OE_OFF;
  endproperty
  a_release: assert property (p_release)
    else $error("pins still driven after read");

  property p_dword_write;
    @(posedge clk) disable iff (!nrst)
    wr_bus.reg_wr || wr_bus.fifo_push
      |-> $past(wr_trail) && $past(st_q.wr_cnt) == pieces - CNT_ONE;
  endproperty
  a_dword_write: assert property (p_dword_write)
    else $error("DWORD write before all pieces");

  property p_warm_quiet;
    @(posedge clk) disable iff (!nrst)
    st_q.warm != WARM_FULL |=> ad_oe_n == OE_OFF && !wr_bus.reg_wr && !wr_bus.fifo_push;
  endproperty
  a_warm_quiet: assert property (p_warm_quiet)
    else $error("bus answered before synchronisers filled");

endmodule : muxed_host_bus_address_latch

// ===== hdl/strobe_sync.sv
// Two-stage synchroniser for a group of asynchronous host pins
`timescale 1ns/100ps
module strobe_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t st_q;
  sync_t st_d;

  // First stage feeds only the second
  always_comb
  begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign q = st_q.s2;

endmodule : strobe_sync

// ===== verification/host_model.sv
// Host processor model on the multiplexed address/data bus
`timescale 1ns/100ps
module host_model
  import host_port_pkg::*;
(
  input  wire logic            clk,
  input  wire cfg_t            cfg,
  input  wire logic [AD_W-1:0] ad_out,
  input  wire logic [AD_W-1:0] ad_oe_n,
  output strobe_t              pins,
  output logic      [AD_W-1:0] ad_in
);
  logic            a_cs, a_rd, a_wr, a_lo, a_hi;
  logic [AD_W-1:0] hv;

  initial
  begin
    {a_cs, a_rd, a_wr, a_lo, a_hi} = 5'h00;
    hv = 16'h0000;
  end

  assign pins = {a_cs ~^ cfg.cs_pol, a_rd ~^ cfg.rd_pol, a_wr ~^ cfg.wr_pol,
                 a_lo ~^ cfg.lo_pol, a_hi ~^ cfg.hi_pol};
  // released lines show the inverse of the last value
  assign ad_in = (~ad_oe_n & ad_out) | (ad_oe_n & hv);

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // address phase, held around the strobe
  task automatic adr(input logic hi, input logic [AD_W-1:0] v, input logic cs);
    hv <= v;
    tick(4);
    a_cs <= cs;
    if (hi)
      a_hi <= 1'b1;
    else
      a_lo <= 1'b1;
    tick(4);
    a_hi <= 1'b0;
    a_lo <= 1'b0;
    tick(4);
    a_cs <= 1'b0;
    hv   <= ~v;
    tick(1);
  endtask : adr

  task automatic wr(input logic [AD_W-1:0] v);
    hv   <= v;
    a_rd <= 1'b0;
    tick(4);
    a_cs <= 1'b1;
    a_wr <= 1'b1;
    tick(4);
    a_cs <= 1'b0;
    a_wr <= 1'b0;
    tick(4);
    hv <= ~v;
    tick(1);
  endtask : wr

  // one read piece, sampled once the device drives
  task automatic rd(output logic [AD_W-1:0] v, output logic [AD_W-1:0] oe);
    a_cs <= 1'b1;
    a_rd <= 1'b1;
    a_wr <= cfg.enb_mode;
    tick(6);
    v  = ad_in;
    oe = ad_oe_n;
    a_cs <= 1'b0;
    a_rd <= 1'b0;
    a_wr <= 1'b0;
    tick(6);
  endtask : rd
endmodule : host_model

// ===== verification/muxed_host_bus_address_latch_tb.sv
// Testbench for the multiplexed host bus port
`timescale 1ns/100ps
module muxed_host_bus_address_latch_tb
  import host_port_pkg::*;
;
  logic              clk, nrst, big_endian, fifo_sel, rd_done, rd_fifo_pop;
  cfg_t              cfg;
  strobe_t           pins;
  logic [AD_W-1:0]   ad_in, ad_out, ad_oe_n, v, oe;
  logic [DW-1:0]     rd_data, last_d;
  logic [ADDR_W-1:0] lat_addr, last_a;
  wr_bus_t           wr_bus;
  int                err_total, compares, n_reg, n_push, n_done, n_pop;

  always #4 clk = ~clk;

  muxed_host_bus_address_latch muxed_host_bus_address_latch_inst (
    .clk(clk), .nrst(nrst), .cfg(cfg), .pins(pins), .ad_in(ad_in), .ad_out(ad_out),
    .ad_oe_n(ad_oe_n), .rd_data(rd_data), .lat_addr(lat_addr), .big_endian(big_endian),
    .fifo_sel(fifo_sel), .wr_bus(wr_bus), .rd_done(rd_done), .rd_fifo_pop(rd_fifo_pop));

  host_model host_model_inst (
    .clk(clk), .cfg(cfg), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .pins(pins), .ad_in(ad_in));

  // Pulses are counted so a doubled or missing one shows
  always @(posedge clk)
  begin
    if (wr_bus.reg_wr === 1'b1) n_reg++;
    if (wr_bus.fifo_push === 1'b1) n_push++;
    if (rd_done === 1'b1) n_done++;
    if (rd_fifo_pop === 1'b1) n_pop++;
    if (wr_bus.reg_wr === 1'b1 || wr_bus.fifo_push === 1'b1)
    begin
      last_d = wr_bus.data;
      last_a = wr_bus.addr;
    end
  end

  task automatic chk(input string nm, input logic [DW-1:0] e, input logic [DW-1:0] g);
    compares++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic rst;
    nrst <= 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
  endtask : rst

  task automatic report_and_stop;
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    report_and_stop;
  end

  initial
  begin
    clk = 1'b0;
    nrst <= 1'b0;
    cfg <= 9'h100;
    rd_data <= 32'h0000_0000;
    rst;
    chk("oe_rst", OE_OFF, ad_oe_n);
    chk("lat_rst", ADDR_RST, lat_addr);
    host_model_inst.adr(1'b0, 16'h02D2, 1'b0);
    chk("lat16", 10'h1A4, lat_addr);
    chk("big16", 1'b1, big_endian);
    chk("fifo16", 1'b0, fifo_sel);
    host_model_inst.wr(16'hBEEF);
    host_model_inst.adr(1'b0, 16'h02D3, 1'b1);
    host_model_inst.wr(16'h1234);
    host_model_inst.tick(2);
    chk("nreg", 1, n_reg);
    chk("wdata16", 32'hBEEF_1234, last_d);
    chk("waddr16", 10'h1A4, last_a);
    chk("npush0", 0, n_push);
    rd_data <= 32'hCAFE_F00D;
    host_model_inst.adr(1'b0, 16'h02D2, 1'b1);
    host_model_inst.rd(v, oe);
    chk("rd16a", 16'hCAFE, v);
    chk("oe16", OE_ALL, oe);
    rd_data <= 32'h0000_0000;
    host_model_inst.adr(1'b0, 16'h02D3, 1'b1);
    host_model_inst.rd(v, oe);
    chk("rd16b", 16'hF00D, v);
    chk("ndone", 1, n_done);
    cfg <= 9'h0FF;
    rst;
    host_model_inst.adr(1'b1, 16'h000A, 1'b1);
    for (int k = 0; k < 4; k++)
    begin
      host_model_inst.adr(1'b0, 16'h00C8 + 16'(k), 1'b1);
      host_model_inst.wr(16'hA500 | (16'h0011 * 16'(k + 1)));
    end
    host_model_inst.tick(2);
    chk("lat8", 10'h2CB, lat_addr);
    chk("fifo8", 1'b1, fifo_sel);
    chk("big8", 1'b0, big_endian);
    chk("npush", 1, n_push);
    chk("wdata8", 32'h4433_2211, last_d);
    chk("waddr8", 10'h2C8, last_a);
    rd_data <= 32'h89AB_CDEF;
    for (int k = 0; k < 4; k++)
    begin
      host_model_inst.adr(1'b0, 16'h00C8 + 16'(k), 1'b1);
      host_model_inst.rd(v, oe);
      chk("rd8", (32'h89AB_CDEF >> (8 * k)) & 32'h0000_00FF, {24'h00_0000, v[7:0]});
      chk("oe8", OE_LOW8, oe);
    end
    chk("npop", 1, n_pop);
    chk("ndone8", 1, n_done);
    host_model_inst.adr(1'b0, 16'h0000, 1'b0);
    chk("lat_nocs", 10'h2CB, lat_addr);
    cfg <= 9'h034;
    rst;
    chk("lat_rst2", ADDR_RST, lat_addr);
    chk("fifo_rst2", 1'b0, fifo_sel);
    host_model_inst.adr(1'b0, 16'hA6B5, 1'b1);
    chk("lat8s", 10'h2B5, lat_addr);
    chk("big8s", 1'b1, big_endian);
    chk("fifo8s", 1'b0, fifo_sel);
    for (int k = 0; k < 4; k++)
    begin
      host_model_inst.adr(1'b0, 16'h06B4 + 16'(k), 1'b1);
      host_model_inst.wr(16'h0011 * 16'(k + 1));
    end
    host_model_inst.tick(2);
    chk("nreg8s", 2, n_reg);
    chk("wdata8s", 32'h1122_3344, last_d);
    chk("waddr8s", 10'h2B4, last_a);
    rd_data <= 32'h0123_4567;
    for (int k = 0; k < 4; k++)
    begin
      host_model_inst.adr(1'b0, 16'h06B4 + 16'(k), 1'b1);
      host_model_inst.rd(v, oe);
      chk("rd8s", (32'h0123_4567 >> (8 * (3 - k))) & 32'h0000_00FF, {24'h00_0000, v[7:0]});
      chk("oe8s", OE_LOW8, oe);
    end
    chk("ndone8s", 2, n_done);
    report_and_stop;
  end
endmodule : muxed_host_bus_address_latch_tb
